// ### hdl/gcsm_gate.v
// glitch-free gate for one source clock
`default_nettype none

module gcsm_gate (
  // source clock and reset
  input  wire clk,
  input  wire nrst,
  // gate request from other domains, gate state in this domain
  input  wire req,
  output reg  en
);

  wire req_sync;

  // bring the request into this source's own domain
  gcsm_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_req_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (req),
    .q    (req_sync)
  );

  // gate opens and closes only while the source is low
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      en <= 1'b0;
    end else begin
      en <= req_sync; // RULE15
    end
  end

endmodule

`default_nettype wire

// ### hdl/gcsm_sync.v
// two-flop level synchroniser with a constant reset value
`default_nettype none

module gcsm_sync #(
  parameter       WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  // data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ### hdl/gcsm_top.v
// four-way clock source mux with network enable and axi4-lite control
//
// Contract
// RULE1: in global mode the output feeds a low-skew network and switches among up to four sources by select.
// RULE2: in external-path mode one pll clock goes to the output pin with no source switching.
// RULE3: the source count is one to four, and above one only in global mode.
// RULE4: with the enable built, high passes the selected clock and low stops the network.
// RULE5: without the enable built, the clock always passes as if enable were high.
// RULE6: with glitch-free switching and several sources, a select change makes no glitch or runt.
// RULE7: the current source must toggle before a change, else the switch cannot complete.
// RULE8: the select defaults to 00, source zero.
// RULE9: new select values are read only while source zero is clocked.
// RULE10: select 00, 01, 10, 11 route sources zero, one, two, three to the output.
// RULE11: the select is two bits and reads as ground when not connected.
// RULE12: with the select connected only the global network may be driven.
// RULE13: the source input is a four-bit vector of pins, pll clocks or core signals.
// RULE14: there is exactly one buffered clock output.
// RULE15: switching gates the old source off low, syncs into the new domain, then ungates it low.
`include "gcsm_consts.vh"
`default_nettype none

module gcsm_top #(
  parameter GLOBAL_MODE = 1,
  parameter NUM_SOURCES = 4,
  parameter HAS_ENA     = 1,
  parameter HAS_SELECT  = 1,
  parameter GLITCH_FREE = 1
) (
  // clock and reset
  input  wire                    ref_clk,
  input  wire                    nrst,
  // source clocks and buffered output
  input  wire [3:0]              src_clk, // RULE13
  output wire                    out_clk,
  // axi4-lite write address
  input  wire [`GCSM_ADDR_W-1:0] s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  // axi4-lite write data
  input  wire [`GCSM_DATA_W-1:0] s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  // axi4-lite read address
  input  wire [`GCSM_ADDR_W-1:0] s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  // axi4-lite read data
  output reg  [`GCSM_DATA_W-1:0] s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready
);

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------

  // external path carries one source only
  localparam CLAMP_SOURCES = (NUM_SOURCES > 4) ? 4 : ((NUM_SOURCES < 1) ? 1 : NUM_SOURCES);
  localparam EFF_SOURCES   = (GLOBAL_MODE != 0) ? CLAMP_SOURCES : 1; // RULE3 RULE2
  // select is honoured only when it may be connected
  localparam SEL_USED      = (GLOBAL_MODE != 0) && (HAS_SELECT != 0) && (EFF_SOURCES > 1); // RULE12 RULE11
  localparam [1:0] EFF_M1  = (EFF_SOURCES == 4) ? 2'h3 : (EFF_SOURCES == 3) ? 2'h2 :
                             (EFF_SOURCES == 2) ? 2'h1 : 2'h0;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // one-hot gate state to source index
  function [1:0] gate_index;
    input [3:0] onehot;
    begin
      gate_index = 2'h0;
      if (onehot[1]) gate_index = 2'h1;
      if (onehot[2]) gate_index = 2'h2;
      if (onehot[3]) gate_index = 2'h3;
    end
  endfunction

  // word-aligned address match
  function addr_hit;
    input [`GCSM_ADDR_W-1:0] addr;
    input [`GCSM_ADDR_W-1:0] target;
    begin
      addr_hit = (addr[`GCSM_ADDR_W-1:2] == target[`GCSM_ADDR_W-1:2]);
    end
  endfunction

  // ----------------------------------------------------------------
  // register bus state
  // ----------------------------------------------------------------

  reg                     aw_held_reg;
  reg [`GCSM_ADDR_W-1:0]  awaddr_reg;
  reg                     w_held_reg;
  reg [`GCSM_DATA_W-1:0]  wdata_reg;
  reg [3:0]               wstrb_reg;
  reg [2:0]               ctrl_reg;

  wire                    aw_take;
  wire                    w_take;
  wire                    have_aw;
  wire                    have_w;
  wire [`GCSM_ADDR_W-1:0] wr_addr;
  wire [`GCSM_DATA_W-1:0] wr_data;
  wire [3:0]              wr_strb;
  wire                    ar_take;

  // one write in flight, channels accepted in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign have_aw = aw_held_reg || aw_take;
  assign have_w  = w_held_reg || w_take;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------
  // write channel and control register
  // ----------------------------------------------------------------

  // address and data are held until both are here, then answered
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg  <= 1'b0;
      awaddr_reg   <= {`GCSM_ADDR_W{1'b0}};
      w_held_reg   <= 1'b0;
      wdata_reg    <= {`GCSM_DATA_W{1'b0}};
      wstrb_reg    <= 4'h0;
      ctrl_reg     <= `GCSM_CTRL_RST; // RULE8
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GCSM_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (have_aw && have_w) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (addr_hit(wr_addr, `GCSM_ADDR_CTRL)) begin
          s_axi_bresp <= `GCSM_RESP_OKAY;
          if (wr_strb[0]) begin
            ctrl_reg <= wr_data[2:0];
          end
        end else if (addr_hit(wr_addr, `GCSM_ADDR_STATUS) || addr_hit(wr_addr, `GCSM_ADDR_CONFIG)) begin
          s_axi_bresp <= `GCSM_RESP_OKAY; // read-only, write dropped
        end else begin
          s_axi_bresp <= `GCSM_RESP_SLVERR;
        end
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          awaddr_reg  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          wdata_reg  <= s_axi_wdata;
          wstrb_reg  <= s_axi_wstrb;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // select and enable in the source-zero domain
  // ----------------------------------------------------------------

  wire [2:0] ctrl_src0;
  reg  [2:0] ctrl_prev_reg;
  reg  [1:0] sel_cur_reg;
  reg        ena_cur_reg;

  // control crosses on source zero, so it needs source zero running
  gcsm_sync #(
    .WIDTH   (3),
    .RST_VAL (`GCSM_CTRL_RST)
  ) u_ctrl_sync (
    .clk  (src_clk[0]),
    .nrst (nrst),
    .d    (ctrl_reg),
    .q    (ctrl_src0)
  ); // RULE9

  // accept a value only once two samples agree, masking skew between bits
  always @(posedge src_clk[0] or negedge nrst) begin
    if (!nrst) begin
      ctrl_prev_reg <= `GCSM_CTRL_RST;
      sel_cur_reg   <= `GCSM_SEL_RST; // RULE8
      ena_cur_reg   <= 1'b1;
    end else begin
      ctrl_prev_reg <= ctrl_src0;
      if (ctrl_src0 == ctrl_prev_reg) begin
        sel_cur_reg <= ctrl_src0[`GCSM_CTRL_SEL_MSB:`GCSM_CTRL_SEL_LSB]; // RULE9
        ena_cur_reg <= ctrl_src0[`GCSM_CTRL_ENA_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // effective select and enable
  // ----------------------------------------------------------------

  wire [1:0] sel_eff;
  wire       ena_eff;

  // unconnected or out-of-range select reads as source zero
  assign sel_eff = (SEL_USED && (sel_cur_reg <= EFF_M1)) ? sel_cur_reg : 2'h0; // RULE11 RULE10
  // missing enable behaves as tied high
  assign ena_eff = (HAS_ENA != 0) ? ena_cur_reg : 1'b1; // RULE5 RULE4

  // ----------------------------------------------------------------
  // per-source gates
  // ----------------------------------------------------------------

  wire [3:0] gate_en;
  wire [3:0] gate_req;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
      if (gi < EFF_SOURCES) begin : g_used
        // a source opens only when every other gate is shut
        assign gate_req[gi] = ({30'h0, sel_eff} == gi) && ena_eff &&
                              !(|(gate_en & ~(4'h1 << gi))); // RULE15 RULE6
        gcsm_gate u_gate (
          .clk  (src_clk[gi]),
          .nrst (nrst),
          .req  (gate_req[gi]),
          .en   (gate_en[gi])
        ); // RULE7
      end else begin : g_unused
        assign gate_req[gi] = 1'b0;
        assign gate_en[gi]  = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // clock output
  // ----------------------------------------------------------------

  wire gf_clk;
  wire direct_clk;

  // gated sources combined; at most one gate is ever open
  assign gf_clk     = |(src_clk & gate_en); // RULE6 RULE1
  // plain mux when glitch-free switching is not built
  assign direct_clk = src_clk[sel_eff] && ena_eff; // RULE10 RULE4
  // single buffered output for network or pin
  assign out_clk    = (GLITCH_FREE != 0) ? gf_clk : direct_clk; // RULE14 RULE2

  // ----------------------------------------------------------------
  // status and read channel
  // ----------------------------------------------------------------

  wire [3:0]              gate_en_ref;
  wire [1:0]              act_src;
  wire                    running;
  wire                    pending;
  wire [1:0]              req_sel;
  reg  [`GCSM_DATA_W-1:0] rd_word;
  reg  [1:0]              rd_resp;

  // gate states brought back for software
  gcsm_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h0)
  ) u_stat_sync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    (gate_en),
    .q    (gate_en_ref)
  );

  // pending stays high while a switch waits on a stopped source
  assign req_sel = (SEL_USED && (ctrl_reg[1:0] <= EFF_M1)) ? ctrl_reg[1:0] : 2'h0;
  assign act_src = gate_index(gate_en_ref);
  assign running = |gate_en_ref;
  assign pending = ((HAS_ENA == 0) || ctrl_reg[`GCSM_CTRL_ENA_BIT]) ?
                   (!running || (act_src != req_sel)) : running; // RULE7

  // read decode, unmapped addresses answer slverr
  always @* begin
    rd_word = {`GCSM_DATA_W{1'b0}};
    rd_resp = `GCSM_RESP_OKAY;
    if (addr_hit(s_axi_araddr, `GCSM_ADDR_CTRL)) begin
      rd_word[2:0] = ctrl_reg;
    end else if (addr_hit(s_axi_araddr, `GCSM_ADDR_STATUS)) begin
      rd_word[`GCSM_STAT_ACT_MSB:`GCSM_STAT_ACT_LSB] = act_src;
      rd_word[`GCSM_STAT_RUN_BIT]  = running;
      rd_word[`GCSM_STAT_PEND_BIT] = pending;
    end else if (addr_hit(s_axi_araddr, `GCSM_ADDR_CONFIG)) begin
      rd_word[1:0] = EFF_M1;
      rd_word[2]   = (GLOBAL_MODE != 0);
      rd_word[3]   = (HAS_ENA != 0);
      rd_word[4]   = (GLITCH_FREE != 0);
      rd_word[5]   = SEL_USED;
    end else begin
      rd_resp = `GCSM_RESP_SLVERR;
    end
  end

  // read answer one cycle after the address is taken
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= {`GCSM_DATA_W{1'b0}};
      s_axi_rresp  <= `GCSM_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### include/gcsm_consts.vh
// register map, field positions and reset values of the clock source mux
`ifndef GCSM_CONSTS_VH
`define GCSM_CONSTS_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define GCSM_ADDR_W        8
`define GCSM_DATA_W        32

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define GCSM_ADDR_CTRL     8'h00
`define GCSM_ADDR_STATUS   8'h04
`define GCSM_ADDR_CONFIG   8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GCSM_CTRL_SEL_LSB  0
`define GCSM_CTRL_SEL_MSB  1
`define GCSM_CTRL_ENA_BIT  2
`define GCSM_STAT_ACT_LSB  0
`define GCSM_STAT_ACT_MSB  1
`define GCSM_STAT_RUN_BIT  2
`define GCSM_STAT_PEND_BIT 3

// ----------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------
`define GCSM_CTRL_RST      3'h4
`define GCSM_SEL_RST       2'h0
`define GCSM_RESP_OKAY     2'h0
`define GCSM_RESP_SLVERR   2'h2

`endif

// ### verification/gcsm_src_model.sv
// four source clocks that the bench may stop one by one
`default_nettype none

module gcsm_src_model (
  // stop requests from the bench
  input  wire logic [3:0] stop,
  // source clocks
  output var logic  [3:0] src_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  // unrelated rates; a stopped source holds its level
  for (genvar gi = 0; gi < 4; gi++) begin : g_src
    localparam real HALF = 7.1 + 2.3 * gi;
    initial begin
      src_clk[gi] = 1'b0;
      forever #(HALF) if (!stop[gi]) src_clk[gi] = ~src_clk[gi];
    end
  end
endmodule

`default_nettype wire

// ### verification/gcsm_top_asserts.sv
// concurrent checks on the ports of the clock source mux
`default_nettype none

module gcsm_top_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // clock path
  input wire logic [3:0]  src_clk,
  input wire logic        out_clk,
  // write handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read handshakes
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // all checks run on the bus clock
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_out_has_src: assert property (out_clk |-> |src_clk)
    else $error("output high with every source low");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_aw_refused: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not retired");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule

`default_nettype wire

// ### verification/gcsm_top_tb.sv
// self-checking bench for the clock source mux
`include "gcsm_consts.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module gcsm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk, nrst, out_clk, out_clk_x;
  logic [3:0]  src_clk, stop, wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, n_tests;

  gcsm_src_model u_src (.stop(stop), .src_clk(src_clk));

  gcsm_top uut (
    .ref_clk(ref_clk), .nrst(nrst), .src_clk(src_clk), .out_clk(out_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // external-path build: one source, select and enable ignored, plain mux
  gcsm_top #(
    .GLOBAL_MODE(0), .NUM_SOURCES(4), .HAS_ENA(0), .HAS_SELECT(1), .GLITCH_FREE(0)
  ) uut_ext (
    .ref_clk(ref_clk), .nrst(nrst), .src_clk(src_clk), .out_clk(out_clk_x),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready)
  );

  // bus clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one write; address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", `GCSM_RESP_OKAY, bresp)
  endtask

  // one read
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // poll status until the source and enable have settled
  task automatic wait_sel(input logic [1:0] s, input logic e);
    int n;
    logic [3:0] g;
    n = 0;
    do begin
      axr(`GCSM_ADDR_STATUS, d, r);
      g = e ? d[3:0] : {d[3:2], 2'b00};
      n++;
    end while (g !== {1'b0, e, e ? s : 2'b00} && n < 200);
    `CHK("status", {1'b0, e, e ? s : 2'b00}, g)
  endtask

  // output tracks the chosen source, or stays low when disabled
  task automatic follow(input int s, input logic e);
    logic l;
    repeat (12) begin
      l = src_clk[s];
      wait (src_clk[s] !== l);
      #1;
      `CHK("out_clk", e & src_clk[s], out_clk)
    end
    // external-path build always carries source zero
    repeat (4) begin
      l = src_clk[0];
      wait (src_clk[0] !== l);
      #1;
      `CHK("ext out_clk", src_clk[0], out_clk_x)
    end
  endtask

  task automatic t_reset();
    axr(`GCSM_ADDR_CTRL, d, r);
    `CHK("ctrl", 32'h4, d)
    axr(`GCSM_ADDR_CONFIG, d, r);
    `CHK("config", 32'h3F, d)
    wait_sel(2'h0, 1'b1);
    follow(0, 1'b1);
  endtask

  task automatic t_decode();
    for (int i = 1; i < 5; i++) begin
      axw(`GCSM_ADDR_CTRL, 32'h4 | (i % 4));
      wait_sel(2'(i % 4), 1'b1);
      follow(i % 4, 1'b1);
    end
  endtask

  task automatic t_enable();
    axw(`GCSM_ADDR_CTRL, 32'h1);
    wait_sel(2'h1, 1'b0);
    follow(1, 1'b0);
    axw(`GCSM_ADDR_CTRL, 32'h5);
    wait_sel(2'h1, 1'b1);
    follow(1, 1'b1);
  endtask

  task automatic t_regs();
    axr(8'h0C, d, r);
    `CHK("unmapped resp", `GCSM_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
    axw(`GCSM_ADDR_STATUS, 32'hFFFFFFFF);
    axw(`GCSM_ADDR_CTRL, 32'hFFFFFFF6);
    axr(`GCSM_ADDR_CTRL, d, r);
    `CHK("ctrl", 32'h6, d)
    wstrb <= 4'hE;
    axw(`GCSM_ADDR_CTRL, 32'h1);
    wstrb <= 4'hF;
    axr(`GCSM_ADDR_CTRL, d, r);
    `CHK("ctrl strobe", 32'h6, d)
    wait_sel(2'h2, 1'b1);
  endtask

  // a stopped current source blocks the switch until it runs again
  task automatic t_stuck();
    @(posedge ref_clk);
    stop <= 4'h4;
    axw(`GCSM_ADDR_CTRL, 32'h7);
    repeat (100) @(posedge ref_clk);
    axr(`GCSM_ADDR_STATUS, d, r);
    `CHK("stuck status", 4'hE, d[3:0])
    stop <= 4'h0;
    wait_sel(2'h3, 1'b1);
  endtask

  // with source zero stopped a new select is not taken
  task automatic t_src0();
    @(posedge ref_clk);
    stop <= 4'h1;
    axw(`GCSM_ADDR_CTRL, 32'h4);
    repeat (100) @(posedge ref_clk);
    axr(`GCSM_ADDR_STATUS, d, r);
    `CHK("held source", 2'h3, d[1:0])
    stop <= 4'h0;
    wait_sel(2'h0, 1'b1);
    follow(0, 1'b1);
  endtask

  // stimulus
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    stop = 4'h0;
    nrst = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_decode();
    t_enable();
    t_regs();
    t_stuck();
    t_src0();
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    #400us;
    miscompares++;
    tally_and_finish();
  end
endmodule

bind gcsm_top gcsm_top_asserts u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .src_clk(src_clk), .out_clk(out_clk),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

`default_nettype wire
